// [hw/i2c_target_pkg.sv]
// Shared constants and types of the serial target engine.
// Notes on behaviour
// - First byte: address bits 7-1, direction bit 0.
// - Target acknowledges each received byte it accepts.
// - Target shifts out; controller acks or nacks.
// - Transmitter drives data bits, receiver drives ack.
// - Stretch clock only at ack edge, every byte.
// - Release on flag cleared or DMA done.
// - Timeout needs enable and unsplit 16-bit timer.
// - Timer reloads while clock high, counts low.
// - High speed after START, master code, NACK.
// - STOP returns the bus to normal speed.
// - High speed followed with no software action.
// - CPU mode by default for both directions.
// - DMA mode still waits flag clear after address.
// - Enabled DMA channels select DMA per direction.
// - Interrupt on status set or active falling.
// - Own address matched and acked by hardware.
`default_nettype none
package i2c_target_pkg;
  localparam logic [3:0]  BYTE_BITS    = 4'h8;
  localparam logic [3:0]  BIT_CNT_RST  = 4'h0;
  localparam logic [3:0]  TX_FIRST_CNT = 4'h1;
  localparam logic [4:0]  HS_CODE_HI   = 5'h01;
  localparam int          DIR_POS      = 0;
  localparam int          ADDR_LSB     = 1;
  localparam int          ADDR_MSB     = 7;
  localparam int          HS_LSB       = 3;
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam logic [15:0] TMR_RST      = 16'h0000;
  localparam logic [15:0] TMR_MAX      = 16'hFFFF;

  typedef enum logic [1:0] {
    EV_ADDR_RD, EV_ADDR_WR, EV_DATA_RX, EV_DATA_TX
  } event_kind_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_RX, ST_CODE, ST_ACK_OUT, ST_TX, ST_ACK_IN,
    ST_HOLD, ST_IGNORE
  } link_state_t;
endpackage
`default_nettype wire

// [hw/i2c_pin_sync.sv]
// Three-stage synchroniser that accepts a change once two stages agree.
`default_nettype none
module i2c_pin_sync #(
  parameter int          WIDTH = 1,
  parameter logic [31:0] INIT  = 32'h0000_0000
) (
  input  wire logic             i_clk,   // Destination clock
  input  wire logic             i_rst_n, // Synchronous reset, active low
  input  wire logic             i_en,    // Clock enable
  input  wire logic [WIDTH-1:0] i_d,     // Asynchronous input
  output logic      [WIDTH-1:0] o_q      // Filtered, synchronised level
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  wire  [WIDTH-1:0] agree = ~(s2_ff ^ s3_ff);
  wire  [WIDTH-1:0] nxt_q = (agree & s3_ff) | (~agree & o_q);

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s1_ff <= INIT[WIDTH-1:0];
      s2_ff <= INIT[WIDTH-1:0];
      s3_ff <= INIT[WIDTH-1:0];
      o_q   <= INIT[WIDTH-1:0];
    end else if (i_en) begin
      s1_ff <= i_d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      o_q   <= nxt_q;
    end
  end
endmodule // i2c_pin_sync
`default_nettype wire

// [hw/i2c_aux_timer.sv]
// Auxiliary 16-bit auto-reload timer with clock-low timeout gating.
`default_nettype none
module i2c_aux_timer #(
  parameter int WIDTH = 16
) (
  input  wire logic             i_clk,       // System clock
  input  wire logic             i_rst_n,     // Synchronous reset, active low
  input  wire logic             i_en,        // Clock enable
  input  wire logic             i_run,       // Timer runs
  input  wire logic             i_split,     // Split setting
  input  wire logic             i_tout_en,   // Clock-low timeout enable
  input  wire logic             i_scl,       // Synchronised clock line
  input  wire logic [WIDTH-1:0] i_reload,    // Reload value
  output logic      [WIDTH-1:0] o_count,     // Current count
  output logic                  o_overflow   // One-cycle overflow pulse
);
  wire             tout_active = i_tout_en & ~i_split;
  wire             force_load  = tout_active & i_scl;
  wire             at_top      = (o_count == {WIDTH{1'b1}});
  wire             wrap        = i_run & ~force_load & at_top;
  wire [WIDTH-1:0] nxt_count   = force_load ? i_reload :
                                 wrap       ? i_reload :
                                 i_run      ? o_count + 1'b1 : o_count;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_count    <= '0;
      o_overflow <= 1'b0;
    end else if (i_en) begin
      o_count    <= nxt_count;
      o_overflow <= wrap;
    end
  end

  tout_reload_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_en && i_tout_en && !i_split && i_scl) |=> (o_count == $past(i_reload)))
    else $error("Timer did not reload while the clock line was high.");
endmodule // i2c_aux_timer
`default_nettype wire

// [hw/i2c_target_transfer_engine.sv]
// Target-only two-wire transfer engine with clock stretching and DMA.
`default_nettype none
module i2c_target_transfer_engine (
  input  wire logic        i_sys_clk,        // System clock, 100 MHz
  input  wire logic        i_rst_n,          // System reset, sync, low
  input  wire logic        i_clk_en,         // Freezes system state when low
  input  wire logic        i_link_clk,       // Line sampling clock
  input  wire logic        i_link_rst_n,     // Link reset, sync, low
  input  wire logic        i_scl,            // Clock line level
  input  wire logic        i_sda,            // Data line level
  output logic             o_scl_o,          // Clock line drive value
  output logic             o_scl_oe,         // Clock line held low
  output logic             o_sda_o,          // Data line drive value
  output logic             o_sda_oe,         // Data line pulled low
  input  wire logic        i_enable,         // Peripheral enabled
  input  wire logic [6:0]  i_own_addr,       // Own target address
  input  wire logic        i_ack_en,         // Hardware acknowledge enable
  input  wire logic        i_flag_wr,        // Write to transfer event flag
  input  wire logic        i_flag_wdata,     // Value written to the flag
  input  wire logic        i_tx_wr,          // CPU write of transmit byte
  input  wire logic [7:0]  i_tx_data,        // CPU transmit byte
  input  wire logic        i_dma_rx_en,      // DMA channel drains rx byte
  input  wire logic        i_dma_tx_en,      // DMA channel fills tx byte
  input  wire logic        i_dma_wr,         // DMA write of transmit byte
  input  wire logic [7:0]  i_dma_wdata,      // DMA transmit byte
  input  wire logic        i_dma_done,       // DMA finished requested byte
  output logic             o_dma_req,        // DMA byte request
  output logic      [7:0]  o_rx_byte,        // Received byte register
  output logic      [7:0]  o_tx_byte,        // Transmit byte register
  output logic             o_flag,           // Transfer event flag
  output logic             o_rd_stat,        // Read status
  output logic             o_wr_stat,        // Write status
  output logic             o_stop_stat,      // Stop status
  output logic             o_active,         // Transfer active
  output logic             o_hs_mode,        // High-speed mode
  output logic             o_irq,            // Interrupt pulse
  input  wire logic        i_tmr_run,        // Auxiliary timer runs
  input  wire logic        i_tmr_split,      // Auxiliary timer split
  input  wire logic        i_scl_timeout_en, // Clock-low timeout enable
  input  wire logic [15:0] i_tmr_reload,     // Auxiliary timer reload
  output logic      [15:0] o_tmr_count,      // Auxiliary timer count
  output logic             o_tmr_overflow    // Auxiliary timer overflow
);
  // ------------------------------------------------------------------
  // Link domain: line sampling and byte engine
  // ------------------------------------------------------------------
  i2c_target_pkg::link_state_t state_ff, nxt_state;
  i2c_target_pkg::event_kind_t kind_ff, nxt_kind;
  logic [3:0] bitcnt_ff, nxt_bitcnt;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] rx_hold_ff, nxt_rx_hold;
  logic       sda_oe_ff, nxt_sda_oe;
  logic       scl_oe_ff, nxt_scl_oe;
  logic       dir_ff, nxt_dir;
  logic       nack_ff, nxt_nack;
  logic       hs_ff, nxt_hs;
  logic       active_ff, nxt_active;
  logic       evt_tgl_ff, nxt_evt_tgl;
  logic       stop_tgl_ff, nxt_stop_tgl;
  logic       scl_q_ff, sda_q_ff, rel_q_ff;
  logic [1:0] pins_s;
  logic [8:0] cfg_s;
  logic       rel_s;
  logic       rel_tgl_ff;
  logic [7:0] tx_byte_ff;

  i2c_pin_sync #(.WIDTH(2), .INIT(32'h0000_0003)) u_pin_sync (
    .i_clk   (i_link_clk),
    .i_rst_n (i_link_rst_n),
    .i_en    (1'b1),
    .i_d     ({i_scl, i_sda}),
    .o_q     (pins_s)
  );

  // Settings are expected to stay still while the target is addressed.
  i2c_pin_sync #(.WIDTH(9)) u_cfg_sync (
    .i_clk   (i_link_clk),
    .i_rst_n (i_link_rst_n),
    .i_en    (1'b1),
    .i_d     ({i_enable, i_ack_en, i_own_addr}),
    .o_q     (cfg_s)
  );

  i2c_pin_sync #(.WIDTH(1)) u_rel_sync (
    .i_clk   (i_link_clk),
    .i_rst_n (i_link_rst_n),
    .i_en    (1'b1),
    .i_d     (rel_tgl_ff),
    .o_q     (rel_s)
  );

  wire scl_s     = pins_s[1];
  wire sda_s     = pins_s[0];
  wire scl_rise  = scl_s & ~scl_q_ff;
  wire scl_fall  = ~scl_s & scl_q_ff;
  wire start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  wire stop_det  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
  wire rel_seen  = rel_s ^ rel_q_ff;
  wire cfg_en    = cfg_s[8];
  wire cfg_ack   = cfg_s[7];
  wire byte_done = scl_fall & (bitcnt_ff == i2c_target_pkg::BYTE_BITS);
  wire hs_code   = shift_ff[i2c_target_pkg::ADDR_MSB:i2c_target_pkg::HS_LSB]
                   == i2c_target_pkg::HS_CODE_HI;
  wire addr_hit  = cfg_en & (shift_ff[i2c_target_pkg::ADDR_MSB:
                   i2c_target_pkg::ADDR_LSB] == cfg_s[6:0]);
  wire dir_rd    = shift_ff[i2c_target_pkg::DIR_POS];

  always_comb begin
    nxt_state    = state_ff;
    nxt_kind     = kind_ff;
    nxt_bitcnt   = bitcnt_ff;
    nxt_shift    = shift_ff;
    nxt_rx_hold  = rx_hold_ff;
    nxt_sda_oe   = sda_oe_ff;
    nxt_scl_oe   = scl_oe_ff;
    nxt_dir      = dir_ff;
    nxt_nack     = nack_ff;
    nxt_hs       = hs_ff;
    nxt_active   = active_ff;
    nxt_evt_tgl  = evt_tgl_ff;
    nxt_stop_tgl = stop_tgl_ff;
    if (stop_det) begin
      // A STOP frees both lines and leaves high speed.
      nxt_state    = i2c_target_pkg::ST_IDLE;
      nxt_sda_oe   = 1'b0;
      nxt_scl_oe   = 1'b0;
      nxt_hs       = 1'b0;
      nxt_active   = 1'b0;
      nxt_stop_tgl = stop_tgl_ff ^ active_ff;
    end else if (start_det) begin
      nxt_state  = i2c_target_pkg::ST_ADDR;
      nxt_bitcnt = i2c_target_pkg::BIT_CNT_RST;
      nxt_sda_oe = 1'b0;
      nxt_scl_oe = 1'b0;
      nxt_nack   = 1'b0;
    end else begin
      case (state_ff)
        i2c_target_pkg::ST_ADDR, i2c_target_pkg::ST_RX: begin
          if (scl_rise) begin
            nxt_shift  = {shift_ff[6:0], sda_s};
            nxt_bitcnt = bitcnt_ff + 4'h1;
          end else if (byte_done) begin
            if (state_ff == i2c_target_pkg::ST_RX) begin
              nxt_rx_hold = shift_ff;
              nxt_kind    = i2c_target_pkg::EV_DATA_RX;
              nxt_sda_oe  = cfg_ack;
              nxt_state   = i2c_target_pkg::ST_ACK_OUT;
            end else if (hs_code) begin
              nxt_state = i2c_target_pkg::ST_CODE;
            end else if (addr_hit) begin
              nxt_dir    = dir_rd;
              nxt_active = 1'b1;
              nxt_kind   = dir_rd ? i2c_target_pkg::EV_ADDR_RD
                                  : i2c_target_pkg::EV_ADDR_WR;
              nxt_sda_oe = cfg_ack;
              nxt_state  = i2c_target_pkg::ST_ACK_OUT;
            end else begin
              nxt_state = i2c_target_pkg::ST_IGNORE;
            end
          end
        end
        i2c_target_pkg::ST_CODE: begin
          // The master code is never acknowledged; a NACK enters HS.
          if (scl_rise && sda_s) begin
            nxt_hs = 1'b1;
          end
          if (scl_fall) begin
            nxt_state = i2c_target_pkg::ST_IGNORE;
          end
        end
        i2c_target_pkg::ST_ACK_OUT: begin
          if (scl_fall) begin
            nxt_sda_oe  = 1'b0;
            nxt_scl_oe  = 1'b1;
            nxt_evt_tgl = ~evt_tgl_ff;
            nxt_state   = i2c_target_pkg::ST_HOLD;
          end
        end
        i2c_target_pkg::ST_TX: begin
          if (byte_done) begin
            nxt_sda_oe = 1'b0;
            nxt_state  = i2c_target_pkg::ST_ACK_IN;
          end else if (scl_fall) begin
            nxt_sda_oe = ~shift_ff[7];
            nxt_shift  = {shift_ff[6:0], 1'b0};
            nxt_bitcnt = bitcnt_ff + 4'h1;
          end
        end
        i2c_target_pkg::ST_ACK_IN: begin
          if (scl_rise) begin
            nxt_nack = sda_s;
          end
          if (scl_fall) begin
            nxt_scl_oe  = 1'b1;
            nxt_kind    = i2c_target_pkg::EV_DATA_TX;
            nxt_evt_tgl = ~evt_tgl_ff;
            nxt_state   = i2c_target_pkg::ST_HOLD;
          end
        end
        i2c_target_pkg::ST_HOLD: begin
          if (rel_seen) begin
            nxt_scl_oe = 1'b0;
            if (dir_ff && nack_ff) begin
              // After a NACK the data line stays free for STOP or START.
              nxt_state = i2c_target_pkg::ST_IGNORE;
            end else if (dir_ff) begin
              nxt_sda_oe = ~tx_byte_ff[7];
              nxt_shift  = {tx_byte_ff[6:0], 1'b0};
              nxt_bitcnt = i2c_target_pkg::TX_FIRST_CNT;
              nxt_state  = i2c_target_pkg::ST_TX;
            end else begin
              nxt_bitcnt = i2c_target_pkg::BIT_CNT_RST;
              nxt_state  = i2c_target_pkg::ST_RX;
            end
          end
        end
        i2c_target_pkg::ST_IDLE, i2c_target_pkg::ST_IGNORE: begin
          nxt_state = state_ff;
        end
        default: begin
          nxt_state = i2c_target_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (!i_link_rst_n) begin
      state_ff    <= i2c_target_pkg::ST_IDLE;
      kind_ff     <= i2c_target_pkg::EV_ADDR_WR;
      bitcnt_ff   <= i2c_target_pkg::BIT_CNT_RST;
      shift_ff    <= i2c_target_pkg::BYTE_RST;
      rx_hold_ff  <= i2c_target_pkg::BYTE_RST;
      {sda_oe_ff, scl_oe_ff, dir_ff, nack_ff} <= 4'h0;
      {hs_ff, active_ff, evt_tgl_ff, stop_tgl_ff} <= 4'h0;
      {scl_q_ff, sda_q_ff, rel_q_ff} <= 3'h6;
    end else begin
      state_ff    <= nxt_state;
      kind_ff     <= nxt_kind;
      bitcnt_ff   <= nxt_bitcnt;
      shift_ff    <= nxt_shift;
      rx_hold_ff  <= nxt_rx_hold;
      {sda_oe_ff, scl_oe_ff, dir_ff, nack_ff} <=
        {nxt_sda_oe, nxt_scl_oe, nxt_dir, nxt_nack};
      {hs_ff, active_ff, evt_tgl_ff, stop_tgl_ff} <=
        {nxt_hs, nxt_active, nxt_evt_tgl, nxt_stop_tgl};
      {scl_q_ff, sda_q_ff, rel_q_ff} <= {scl_s, sda_s, rel_s};
    end
  end

  assign o_scl_o  = 1'b0;
  assign o_sda_o  = 1'b0;
  assign o_scl_oe = scl_oe_ff;
  assign o_sda_oe = sda_oe_ff;

  // ------------------------------------------------------------------
  // System domain: flag, DMA routing, data registers and status
  // ------------------------------------------------------------------
  logic [3:0] link_s;
  logic       scl_sys_s;
  logic       evt_q_ff, stop_q_ff, active_q_ff;
  logic       flag_ff, dma_req_ff, rd_ff, wr_ff, stop_ff, irq_ff;
  logic [7:0] rx_byte_ff;

  i2c_pin_sync #(.WIDTH(4)) u_link_sync (
    .i_clk   (i_sys_clk),
    .i_rst_n (i_rst_n),
    .i_en    (i_clk_en),
    .i_d     ({evt_tgl_ff, stop_tgl_ff, active_ff, hs_ff}),
    .o_q     (link_s)
  );

  i2c_pin_sync #(.WIDTH(1), .INIT(32'h0000_0001)) u_scl_sys_sync (
    .i_clk   (i_sys_clk),
    .i_rst_n (i_rst_n),
    .i_en    (i_clk_en),
    .i_d     (i_scl),
    .o_q     (scl_sys_s)
  );

  // Kind and received byte stay still while the clock is stretched.
  wire evt_seen  = link_s[3] ^ evt_q_ff;
  wire stop_seen = link_s[2] ^ stop_q_ff;
  wire act_fall  = ~link_s[1] & active_q_ff;
  wire ev_rx     = (kind_ff == i2c_target_pkg::EV_DATA_RX);
  wire ev_tx     = (kind_ff == i2c_target_pkg::EV_DATA_TX);
  wire dma_mode  = (ev_rx & i_dma_rx_en) | (ev_tx & i_dma_tx_en);
  wire flag_set  = evt_seen & ~dma_mode;
  wire dma_set   = evt_seen & dma_mode;
  wire flag_clr  = i_flag_wr & ~i_flag_wdata;
  wire rel_cpu   = flag_clr & flag_ff;
  wire rel_dma   = i_dma_done & dma_req_ff;
  wire rd_set    = evt_seen & (ev_tx | kind_ff == i2c_target_pkg::EV_ADDR_RD);
  wire wr_set    = evt_seen & (ev_rx | kind_ff == i2c_target_pkg::EV_ADDR_WR);
  // A new address restates the direction, dropping bits left by DMA bytes.
  wire addr_evt  = evt_seen & ~ev_rx & ~ev_tx;
  wire irq_cause = rd_set | wr_set | stop_seen | act_fall;
  wire nxt_flag  = flag_set | (flag_ff & ~flag_clr);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      {evt_q_ff, stop_q_ff, active_q_ff} <= 3'h0;
      {flag_ff, dma_req_ff, rel_tgl_ff} <= 3'h0;
      {rd_ff, wr_ff, stop_ff, irq_ff} <= 4'h0;
      rx_byte_ff <= i2c_target_pkg::BYTE_RST;
      tx_byte_ff <= i2c_target_pkg::BYTE_RST;
    end else if (i_clk_en) begin
      {evt_q_ff, stop_q_ff, active_q_ff} <= link_s[3:1];
      flag_ff    <= nxt_flag; // set wins over clear
      dma_req_ff <= dma_set | (dma_req_ff & ~i_dma_done);
      rel_tgl_ff <= rel_tgl_ff ^ (rel_cpu | rel_dma);
      rd_ff      <= rd_set | (rd_ff & ~flag_clr & ~addr_evt);
      wr_ff      <= wr_set | (wr_ff & ~flag_clr & ~addr_evt);
      stop_ff    <= stop_seen | (stop_ff & ~flag_clr);
      irq_ff     <= irq_cause;
      if (evt_seen && ev_rx) begin
        rx_byte_ff <= rx_hold_ff;
      end
      if (i_dma_wr) begin
        tx_byte_ff <= i_dma_wdata;
      end else if (i_tx_wr) begin
        tx_byte_ff <= i_tx_data;
      end
    end
  end

  assign o_dma_req   = dma_req_ff;
  assign o_rx_byte   = rx_byte_ff;
  assign o_tx_byte   = tx_byte_ff;
  assign o_flag      = flag_ff;
  assign o_rd_stat   = rd_ff;
  assign o_wr_stat   = wr_ff;
  assign o_stop_stat = stop_ff;
  assign o_active    = link_s[1];
  assign o_hs_mode   = link_s[0];
  assign o_irq       = irq_ff;

  i2c_aux_timer #(.WIDTH(16)) u_aux_timer (
    .i_clk      (i_sys_clk),
    .i_rst_n    (i_rst_n),
    .i_en       (i_clk_en),
    .i_run      (i_tmr_run),
    .i_split    (i_tmr_split),
    .i_tout_en  (i_scl_timeout_en),
    .i_scl      (scl_sys_s),
    .i_reload   (i_tmr_reload),
    .o_count    (o_tmr_count),
    .o_overflow (o_tmr_overflow)
  );

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  stretch_edge_a: assert property (@(posedge i_link_clk)
    disable iff (!i_link_rst_n) $rose(scl_oe_ff) |-> $past(scl_fall)
      && ($past(state_ff) inside {i2c_target_pkg::ST_ACK_OUT,
                                  i2c_target_pkg::ST_ACK_IN}))
    else $error("Clock held low outside an acknowledge edge.");
  ack_drive_a: assert property (@(posedge i_link_clk)
    disable iff (!i_link_rst_n)
    (state_ff == i2c_target_pkg::ST_ACK_OUT &&
     $past(state_ff) == i2c_target_pkg::ST_RX) |-> sda_oe_ff == cfg_ack)
    else $error("Acknowledge not driven after a received byte.");
  release_a: assert property (@(posedge i_link_clk)
    disable iff (!i_link_rst_n)
    (state_ff == i2c_target_pkg::ST_HOLD && rel_seen && !stop_det &&
     !start_det) |=> !scl_oe_ff)
    else $error("Stretched clock not released.");
  hs_exit_a: assert property (@(posedge i_link_clk)
    disable iff (!i_link_rst_n) stop_det |=> !hs_ff && !active_ff)
    else $error("High speed kept after STOP.");
  hs_entry_a: assert property (@(posedge i_link_clk)
    disable iff (!i_link_rst_n)
    $rose(hs_ff) |-> $past(state_ff) == i2c_target_pkg::ST_CODE)
    else $error("High speed entered without a master code.");
  flag_release_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n) (i_clk_en && rel_cpu && !rel_dma)
      |=> rel_tgl_ff != $past(rel_tgl_ff))
    else $error("Flag clear did not request a release.");
  dma_route_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n) (i_clk_en && evt_seen && ev_rx && i_dma_rx_en)
      |=> dma_req_ff && $stable(flag_ff))
    else $error("DMA receive byte not routed to DMA.");
  addr_flag_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n) (i_clk_en && evt_seen && !ev_rx && !ev_tx)
      |=> flag_ff)
    else $error("Address event did not raise the flag.");
  irq_stop_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n) (i_clk_en && stop_seen) |=> irq_ff && stop_ff)
    else $error("STOP did not raise status and interrupt.");

  addr_read_c: cover property (@(posedge i_link_clk)
    state_ff == i2c_target_pkg::ST_HOLD && dir_ff);
  hs_entry_c: cover property (@(posedge i_link_clk) $rose(hs_ff));
  dma_req_c: cover property (@(posedge i_sys_clk) $rose(dma_req_ff));
  stop_c: cover property (@(posedge i_sys_clk) $rose(stop_ff));
endmodule // i2c_target_transfer_engine
`default_nettype wire

// [testbench/bus_ctl.sv]
// Behavioural bus controller that pulls both lines open drain.
`default_nettype none
module bus_ctl (
  input  wire logic i_scl,     // Wired clock line
  input  wire logic i_sda,     // Wired data line
  output var logic  o_scl_low, // Pulls clock low
  output var logic  o_sda_low, // Pulls data low
  output var logic  o_hang     // Clock never came back
);
  timeunit 1ns;
  timeprecision 1ns;
  int half = 200;
  initial {o_scl_low, o_sda_low, o_hang} = 3'b000;
  // Only ever releases the clock, so a stretch simply delays us.
  task automatic rise();
    int n;
    o_scl_low = 1'b0;
    for (n = 0; n < 3000 && i_scl !== 1'b1; n++) #10;
    if (n == 3000) o_hang = 1'b1;
  endtask
  task automatic bit_io(input logic v, output logic b);
    #50 o_sda_low = ~v;
    #(half - 50) rise();
    #(half) b = i_sda;
    o_scl_low = 1'b1;
  endtask
  task automatic start();
    #50 o_sda_low = 1'b0;
    #(half) rise();
    #(half) o_sda_low = 1'b1;
    #(half) o_scl_low = 1'b1;
  endtask
  task automatic stop();
    #50 o_sda_low = 1'b1;
    #(half) rise();
    #(half) o_sda_low = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ak,
                      output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ak, a);
  endtask
endmodule // bus_ctl
`default_nettype wire

// [testbench/test_i2c_target_transfer_engine.sv]
// Self-checking bench of the serial target engine.
`default_nettype none
module test_i2c_target_transfer_engine;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_sys_clk = 0, i_link_clk = 0, i_rst_n = 0, i_link_rst_n = 0;
  logic i_clk_en = 1, i_enable = 1, i_ack_en = 1, i_flag_wr = 0;
  logic i_flag_wdata = 0, i_tx_wr = 0, i_dma_rx_en = 0, i_dma_tx_en = 0;
  logic i_dma_wr = 0, i_dma_done = 0, i_tmr_run = 0, i_tmr_split = 0;
  logic i_scl_timeout_en = 0, scl_low, sda_low, hang;
  logic [6:0] i_own_addr = 7'h2a;
  logic [7:0] i_tx_data = 0, i_dma_wdata = 0, o_rx_byte, o_tx_byte;
  logic [15:0] i_tmr_reload = 16'hfff0, o_tmr_count;
  logic o_scl_o, o_scl_oe, o_sda_o, o_sda_oe, o_dma_req, o_flag, o_rd_stat;
  logic o_wr_stat, o_stop_stat, o_active, o_hs_mode, o_irq, o_tmr_overflow;
  wire logic i_scl = ~(scl_low | o_scl_oe);
  wire logic i_sda = ~(sda_low | o_sda_oe);
  int seed = 57692, bad_count = 0, checked = 0, irqs = 0, ovfs = 0;
  logic [31:0] r;
  i2c_target_transfer_engine u_i2c_target_transfer_engine (.*);
  bus_ctl u_bus_ctl (.i_scl, .i_sda, .o_scl_low(scl_low),
    .o_sda_low(sda_low), .o_hang(hang));
  initial forever #5 i_sys_clk = ~i_sys_clk;
  initial #3 forever #7.5 i_link_clk = ~i_link_clk;
  always @(posedge i_sys_clk) begin
    irqs <= irqs + int'(o_irq === 1'b1);
    ovfs <= ovfs + int'(o_tmr_overflow === 1'b1);
  end
  task automatic chk(input string n, input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Waits for the byte event, then hands over the next byte and releases.
  task automatic serve(input logic dma, input logic [7:0] nx,
                       input logic [1:0] st);
    @(posedge i_sys_clk);
    for (int n = 0; n < 400 && (dma ? o_dma_req : o_flag) !== 1'b1; n++)
      @(posedge i_sys_clk);
    chk("event", dma ? o_dma_req : o_flag, 1);
    if (bad_count != 0 || hang) stop_test();
    chk("stretch", o_scl_oe, 1);
    if (st != 0) chk("dir", {o_rd_stat, o_wr_stat}, st);
    #1 {i_tx_wr, i_dma_wr, i_tx_data, i_dma_wdata} = {~dma, dma, nx, nx};
    @(posedge i_sys_clk) #1 {i_tx_wr, i_dma_wr} = 2'b00;
    {i_flag_wr, i_dma_done} = {~dma, dma};
    @(posedge i_sys_clk) #1 {i_flag_wr, i_dma_done} = 2'b00;
  endtask
  task automatic txn(input logic rd, input logic dma, input int n);
    logic [7:0] q, d, t;
    logic a;
    @(posedge i_sys_clk) #1 r = $random(seed);
    i_own_addr = {2'b01, r[4:0]};
    {i_dma_rx_en, i_dma_tx_en} = {dma & ~rd, dma & rd};
    repeat (8) @(posedge i_sys_clk);
    u_bus_ctl.start();
    u_bus_ctl.xfer({i_own_addr, rd}, 1'b1, q, a);
    chk("addr_ack", a, 0);
    t = $random(seed);
    serve(0, t, {rd, ~rd});
    for (int i = 0; i < n; i++) begin
      d = $random(seed);
      u_bus_ctl.xfer(rd ? 8'hff : d, ~rd | (i == n - 1), q, a);
      chk("data", rd ? q : {7'h00, a}, rd ? t : 8'h00);
      serve(dma, d, 2'b00);
      if (!rd) chk("rx_byte", o_rx_byte, d);
      t = d;
    end
    u_bus_ctl.stop();
    repeat (20) @(posedge i_sys_clk);
    chk("stop", {o_stop_stat, o_active}, 2'b10);
  endtask
  task automatic idle_byte(input logic [7:0] c, input logic hs);
    logic [7:0] q;
    logic a;
    u_bus_ctl.start();
    u_bus_ctl.xfer(c, 1'b1, q, a);
    u_bus_ctl.half = 200;
    repeat (20) @(posedge i_sys_clk);
    chk("nack", {a, o_flag, o_hs_mode}, {2'b10, hs});
    u_bus_ctl.stop();
    repeat (20) @(posedge i_sys_clk);
    chk("hs_off", o_hs_mode, 0);
  endtask
  initial begin
    repeat (6) @(posedge i_sys_clk);
    chk("reset", {o_flag, o_scl_oe, o_sda_oe, o_rx_byte}, 0);
    #1 {i_rst_n, i_link_rst_n, i_tmr_run, i_scl_timeout_en} = 4'hf;
    repeat (20) @(posedge i_sys_clk);
    chk("reload", o_tmr_count, i_tmr_reload);
    for (int k = 0; k < 4; k++) txn(k[0], k[1], 2 + k);
    idle_byte({2'b10, r[4:0], 1'b0}, 0);
    u_bus_ctl.half = 1250;
    idle_byte({5'h01, r[2:0]}, 1);
    chk("irq", irqs > 0, 1);
    chk("timeout", ovfs > 0, 1);
    chk("hang", hang, 0);
    stop_test();
  end
endmodule // test_i2c_target_transfer_engine
`default_nettype wire
